/* sim/dsr_bus_monitor.sv */
// checker of the two-wire bus between controller and device
`timescale 1ns/1ps
`default_nettype none
`include "dsr_params.svh"
module dsr_bus_monitor (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// bus signals
	input wire logic scl,
	input wire logic sda,
	input wire logic host_scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe
);
	logic scl_q, sda_q, frame_q, rd_q;
	logic [3:0] cnt_q;
	logic [1:0] byt_q;
	logic [7:0] sh_q, lb_q;
	// start and stop are the only sda moves allowed while scl is high
	wire start_w = scl && scl_q && sda_q && !sda;
	wire stop_w = scl && scl_q && !sda_q && sda;
	wire rise_w = scl && !scl_q && frame_q;
	wire ack_w = rise_w && (cnt_q == 4'h8);

	// bit and byte position; a repeated start restarts the count
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			frame_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 4'h0;
			byt_q <= 2'h0;
			sh_q <= 8'h00;
			lb_q <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start_w) begin
				frame_q <= 1'b1;
				cnt_q <= 4'h0;
				byt_q <= 2'h0;
			end else if (stop_w) begin
				frame_q <= 1'b0;
			end else if (rise_w) begin
				sh_q <= {sh_q[6:0], sda};
				cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
				if (cnt_q == 4'h8 && byt_q != 2'h3) byt_q <= byt_q + 2'h1;
				if (cnt_q == 4'h7) lb_q <= {sh_q[6:0], sda};
				if (cnt_q == 4'h7 && byt_q == 2'h0) rd_q <= sda;
			end
		end
	end

	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	AST_IDLE_AFTER_RESET: assert property ($rose(reset_n_i) |-> scl && sda && !dev_sda_oe && !host_scl_oe)
		else $error("bus not idle after reset");
	AST_SILENT_OUTSIDE: assert property (!frame_q && !start_w |-> !dev_sda_oe)
		else $error("device drives outside a frame");
	AST_HOST_FREES_NINTH: assert property (ack_w |-> !host_sda_oe)
		else $error("controller holds sda in ninth slot");
	AST_DEV_STEADY_HIGH: assert property (scl && scl_q |-> $stable(dev_sda_oe))
		else $error("device moved sda while scl high");
	AST_ADDR_ACK: assert property (ack_w && byt_q == 2'h0 |-> sda == (lb_q[7:1] != `DSR_SLAVE_ADDR))
		else $error("address acknowledge wrong");
	AST_CMD_ACK: assert property (ack_w && byt_q == 2'h1 && !rd_q |-> sda == (lb_q > 8'h01))
		else $error("command acknowledge wrong");
	AST_DATA_ACK: assert property (ack_w && byt_q == 2'h2 && !rd_q |-> !sda)
		else $error("written byte not acknowledged");
	AST_READ_HOST_FREE: assert property (rise_w && byt_q == 2'h1 && rd_q |-> !host_sda_oe)
		else $error("controller drives sda during read byte");
	COV_ADDR_ACK: cover property (ack_w && byt_q == 2'h0 && !sda);
	COV_READ_BYTE: cover property (ack_w && byt_q == 2'h1 && rd_q);
	COV_CMD_NACK: cover property (ack_w && byt_q == 2'h1 && !rd_q && sda);
endmodule : dsr_bus_monitor
`default_nettype wire

/* sim/tb_top.sv */
// bench: controller and device on one bus, a bare device on a second one
`timescale 1ns/1ps
`default_nettype none
`include "dsr_params.svh"
module tb_top;
	localparam int QTR = 8;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic pready, pslverr, err, nk, ab, es, standby, standby2;
	logic [7:0] dac_code, dac2_code, ec, r, v, c;
	int n_mismatch = 0;
	int samples_checked = 0;
	integer seed = 32'h9e96;
	dsr_bus_if bus ();
	dsr_bus_if bus2 ();

	// 200 mhz clock, inverted every half period
	always #2.5 mclk_i = ~mclk_i;

	dsr_host #(.QTR_CYC(QTR)) dsr_host_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .bus(bus.host));
	dsr_device dsr_device_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus(bus.dev), .dac_code_o(dac_code),
		.standby_o(standby));
	dsr_device dsr_device_i2 (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .bus(bus2.dev), .dac_code_o(dac2_code),
		.standby_o(standby2));
	dsr_bus_monitor dsr_bus_monitor_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .scl(bus.scl), .sda(bus.sda),
		.host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe));

	// ****************************************
	// tasks
	// ****************************************
	// setup data reads back with reserved bits as zero
	function automatic logic [7:0] exp_rd(input logic [7:0] cmd, input logic [7:0] code, input logic sb);
		return (cmd == `DSR_CMD_SETUP) ? {7'h00, sb} : code;
	endfunction : exp_rd

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk

	// apb master: request held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		do @(posedge mclk_i); while (pready !== 1'b1);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one controller transfer; polling is bounded, the watchdog catches the rest
	task automatic xfer(input logic rd, input logic [7:0] cmd, input logic [7:0] wd);
		int i;
		apb(1'b1, `DSR_REG_WDATA, {24'h0, wd});
		apb(1'b1, `DSR_REG_CMD, {22'h0, 1'b1, rd, cmd});
		i = 0;
		do begin
			apb(1'b0, `DSR_REG_STATUS, 32'h0);
			i++;
		end while (rv[`DSR_ST_DONE_POS] !== 1'b1 && i < 3000);
		// an exhausted poll counts as a mismatch
		chk(32'h2, {30'h0, rv[`DSR_ST_DONE_POS], 1'b0});
		nk = rv[`DSR_ST_NACK_POS];
		apb(1'b1, `DSR_REG_STATUS, 32'h2);
		apb(1'b0, `DSR_REG_RDATA, 32'h0);
		r = rv[7:0];
	endtask : xfer

	// second bus driven by hand, one quarter per call
	task automatic pin(input logic scl_low, input logic sda_low);
		bus2.host_scl_oe <= scl_low;
		bus2.host_sda_oe <= sda_low;
		repeat (QTR) @(posedge mclk_i);
	endtask : pin

	// sda only moves while scl is low; ab holds the ninth-slot level
	task automatic bare_byte(input logic [7:0] b);
		for (int k = 7; k >= 0; k--) begin
			pin(1'b1, bus2.host_sda_oe);
			pin(1'b1, !b[k]);
			pin(1'b0, !b[k]);
		end
		pin(1'b1, bus2.host_sda_oe);
		pin(1'b1, 1'b0);
		pin(1'b0, 1'b0);
		ab = bus2.sda;
		pin(1'b1, 1'b0);
	endtask : bare_byte

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict

	// ****************************************
	// tests
	// ****************************************
	initial begin
		bus2.host_scl_o = 1'b0;
		bus2.host_sda_o = 1'b0;
		bus2.host_scl_oe = 1'b0;
		bus2.host_sda_oe = 1'b0;
		repeat (16) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		chk(32'h0, {24'h0, dac_code});
		chk(32'h0, {31'h0, standby});
		xfer(1'b1, `DSR_CMD_OUTPUT_CODE, 8'h00);
		chk(32'h0, {24'h0, r});
		xfer(1'b1, `DSR_CMD_SETUP, 8'h00);
		chk(32'h0, {24'h0, r});
		$display("test reset done");
		ec = 8'h00;
		es = 1'b0;
		// corner values first, then random ones, into each register
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 5; i++) begin
				c = j ? `DSR_CMD_SETUP : `DSR_CMD_OUTPUT_CODE;
				v = (i == 0) ? 8'hff : (i == 1) ? 8'hfe : (i == 2) ? 8'h01 : 8'($random(seed));
				xfer(1'b0, c, v);
				if (j == 0) ec = v;
				else es = v[`DSR_STANDBY_BIT];
				chk(32'h0, {31'h0, nk});
				chk({24'h0, ec}, {24'h0, dac_code});
				chk({31'h0, es}, {31'h0, standby});
				xfer(1'b1, c, 8'h00);
				chk({24'h0, exp_rd(c, ec, es)}, {24'h0, r});
			end
		end
		$display("test register write and read done");
		c = 8'($random(seed)) | 8'h02;
		xfer(1'b0, c, 8'h5a);
		chk(32'h1, {31'h0, nk});
		chk({24'h0, ec}, {24'h0, dac_code});
		chk({31'h0, es}, {31'h0, standby});
		apb(1'b0, 8'h10, 32'h0);
		chk(32'h1, {31'h0, err});
		chk(32'h0, rv);
		$display("test refusals done");
		// own address without a start, then a wrong address after one
		bare_byte({`DSR_SLAVE_ADDR, `DSR_DIR_WRITE});
		chk(32'h1, {31'h0, ab});
		pin(1'b0, 1'b0);
		pin(1'b0, 1'b1);
		bare_byte({`DSR_SLAVE_ADDR ^ 7'h01, `DSR_DIR_WRITE});
		chk(32'h1, {31'h0, ab});
		// bytes after a refused address must not reach a register
		bare_byte(`DSR_CMD_SETUP);
		bare_byte(8'hff);
		chk(32'h1, {31'h0, ab});
		pin(1'b1, 1'b1);
		pin(1'b0, 1'b1);
		pin(1'b0, 1'b0);
		chk(32'h0, {24'h0, dac2_code});
		chk(32'h0, {31'h0, standby2});
		// a proper write frame by hand puts the bare device in standby
		pin(1'b0, 1'b1);
		bare_byte({`DSR_SLAVE_ADDR, `DSR_DIR_WRITE});
		chk(32'h0, {31'h0, ab});
		bare_byte(`DSR_CMD_SETUP);
		chk(32'h0, {31'h0, ab});
		bare_byte(8'h01);
		chk(32'h0, {31'h0, ab});
		pin(1'b1, 1'b1);
		pin(1'b0, 1'b1);
		pin(1'b0, 1'b0);
		chk(32'h1, {31'h0, standby2});
		$display("test bare device done");
		// a second reset in mid-run must clear both register sets
		reset_n_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		chk(32'h0, {24'h0, dac_code});
		chk(32'h0, {31'h0, standby});
		chk(32'h0, {31'h0, standby2});
		xfer(1'b1, `DSR_CMD_SETUP, 8'h00);
		chk(32'h0, {24'h0, r});
		$display("test mid-run reset done");
		print_verdict();
	end

	// watchdog: 24 transfers of at most 156 quarters plus the hand-driven bytes, doubled
	initial begin
		repeat (8000 * QTR) @(posedge mclk_i);
		n_mismatch++;
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire

/* src/dsr_bus_if.sv */
// two-wire bus between controller and device, open drain with pull-up
`timescale 1ns/1ps
`default_nettype none
interface dsr_bus_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// wired-and: a line is low while any enabled driver pulls low
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host (output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe,
		input scl, input sda);
	modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface : dsr_bus_if
`default_nettype wire

/* src/dsr_device.sv */
// dac serial slave port with output code and setup registers
`timescale 1ns/1ps
`default_nettype none
`include "dsr_params.svh"
module dsr_device import dsr_pkg::*; (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// two-wire bus
	dsr_bus_if.dev bus,
	// converter side
	output logic [7:0] dac_code_o,
	output logic standby_o
);

	// ****************************************
	// helpers
	// ****************************************

	// value returned for a read of the selected register
	function automatic logic [7:0] rd_value(input logic [7:0] cmd, input logic [7:0] code,
		input logic stby);
		logic [7:0] v;
		v = 8'h00;
		if (cmd == `DSR_CMD_OUTPUT_CODE) begin
			v = code;
		end else if (cmd == `DSR_CMD_SETUP) begin
			v = {7'h00, stby};
		end
		return v;
	endfunction : rd_value

	// ****************************************
	// pin synchronisers
	// ****************************************

	logic scl_m_q;
	logic scl_s_q;
	logic scl_p_q;
	logic sda_m_q;
	logic sda_s_q;
	logic sda_p_q;

	// two stages, then one more for edge detection
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_m_q <= bus.scl;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= bus.sda;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	// ****************************************
	// bus conditions
	// ****************************************

	wire start_w;
	wire stop_w;
	wire rise_w;
	wire fall_w;

	// sda moving while scl stays high marks start or stop
	assign start_w = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop_w = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	assign rise_w = scl_s_q & ~scl_p_q;
	assign fall_w = ~scl_s_q & scl_p_q;

	// ****************************************
	// state
	// ****************************************

	dsr_dev_state_e state_q;
	dsr_dev_state_e state_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [7:0] cmd_q;
	logic [7:0] cmd_d;
	logic rw_q;
	logic rw_d;
	logic mack_q;
	logic mack_d;
	logic [7:0] code_q;
	logic [7:0] code_d;
	logic stby_q;
	logic stby_d;

	wire rx_w;
	wire byte_end_w;
	wire addr_hit_w;
	wire cmd_ok_w;

	// receive decode
	assign rx_w = (state_q == DEV_ADDR) | (state_q == DEV_CMD) | (state_q == DEV_WDATA);
	assign byte_end_w = rx_w & fall_w & (cnt_q == 4'd8);
	assign addr_hit_w = (shift_q[7:1] == `DSR_SLAVE_ADDR);
	// unknown commands are refused so a stray write cannot hit a register
	assign cmd_ok_w = (shift_q == `DSR_CMD_OUTPUT_CODE) | (shift_q == `DSR_CMD_SETUP);

	// next state; a start anywhere restarts, a stop anywhere idles
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		cmd_d = cmd_q;
		rw_d = rw_q;
		mack_d = mack_q;
		code_d = code_q;
		stby_d = stby_q;
		if (rx_w && rise_w) begin
			shift_d = {shift_q[6:0], sda_s_q};
			cnt_d = cnt_q + 4'd1;
		end
		if (start_w) begin
			state_d = DEV_ADDR;
			cnt_d = 4'd0;
		end else if (stop_w) begin
			state_d = DEV_IDLE;
		end else begin
			case (state_q)
				DEV_IDLE: begin
					state_d = DEV_IDLE;
				end
				DEV_ADDR: begin
					if (byte_end_w) begin
						if (addr_hit_w) begin
							state_d = DEV_ADDR_ACK;
							rw_d = shift_q[0];
						end else begin
							state_d = DEV_IDLE;
						end
					end
				end
				DEV_CMD: begin
					if (byte_end_w) begin
						if (cmd_ok_w) begin
							state_d = DEV_CMD_ACK;
							cmd_d = shift_q;
						end else begin
							state_d = DEV_IDLE;
						end
					end
				end
				DEV_WDATA: begin
					if (byte_end_w) begin
						state_d = DEV_WDATA_ACK;
						if (cmd_q == `DSR_CMD_OUTPUT_CODE) begin
							code_d = shift_q;
						end else begin
							stby_d = shift_q[`DSR_STANDBY_BIT];
						end
					end
				end
				DEV_ADDR_ACK: begin
					if (fall_w) begin
						cnt_d = 4'd0;
						if (rw_q == `DSR_DIR_READ) begin
							state_d = DEV_RDATA;
							shift_d = rd_value(cmd_q, code_q, stby_q);
						end else begin
							state_d = DEV_CMD;
						end
					end
				end
				DEV_CMD_ACK, DEV_WDATA_ACK: begin
					// further bytes rewrite the same register
					if (fall_w) begin
						state_d = DEV_WDATA;
						cnt_d = 4'd0;
					end
				end
				DEV_RDATA: begin
					if (fall_w) begin
						if (cnt_q == 4'd7) begin
							state_d = DEV_RDATA_ACK;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							cnt_d = cnt_q + 4'd1;
						end
					end
				end
				DEV_RDATA_ACK: begin
					if (rise_w) begin
						mack_d = ~sda_s_q;
					end else if (fall_w) begin
						if (mack_q) begin
							state_d = DEV_RDATA;
							shift_d = rd_value(cmd_q, code_q, stby_q);
							cnt_d = 4'd0;
						end else begin
							state_d = DEV_IDLE;
						end
					end
				end
				default: begin
					state_d = DEV_IDLE;
				end
			endcase
		end
	end

	// protocol registers
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= DEV_IDLE;
			cnt_q <= 4'd0;
			shift_q <= 8'h00;
			cmd_q <= `DSR_CMD_OUTPUT_CODE;
			rw_q <= `DSR_DIR_WRITE;
			mack_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			cmd_q <= cmd_d;
			rw_q <= rw_d;
			mack_q <= mack_d;
		end
	end

	// register file, cleared at power-on
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			code_q <= `DSR_OUTPUT_CODE_RST;
			stby_q <= `DSR_SETUP_RST;
		end else begin
			code_q <= code_d;
			stby_q <= stby_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************

	// open drain: only ever pull low; ack slots and zero read bits
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = (state_q == DEV_ADDR_ACK) | (state_q == DEV_CMD_ACK)
		| (state_q == DEV_WDATA_ACK) | ((state_q == DEV_RDATA) & ~shift_q[7]);
	assign dac_code_o = code_q;
	assign standby_o = stby_q;

endmodule : dsr_device
`default_nettype wire

/* src/dsr_host.sv */
// bus controller: apb registers order one byte write or read of the dac
`timescale 1ns/1ps
`default_nettype none
`include "dsr_params.svh"
module dsr_host import dsr_pkg::*; #(
	parameter int unsigned QTR_CYC = `DSR_QTR_CYC
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// two-wire bus
	dsr_bus_if.host bus
);

	// byte sent in each position of the transfer
	function automatic logic [7:0] tx_byte(input logic [1:0] idx, input logic rd,
		input logic [7:0] cmd, input logic [7:0] wd);
		logic [7:0] v;
		v = 8'hff;
		case (idx)
			2'd0: v = {`DSR_SLAVE_ADDR, `DSR_DIR_WRITE};
			2'd1: v = cmd;
			2'd2: v = rd ? {`DSR_SLAVE_ADDR, `DSR_DIR_READ} : wd;
			default: v = 8'hff;
		endcase
		return v;
	endfunction : tx_byte

	// ****************************************
	// apb decode
	// ****************************************
	dsr_host_state_e state_q;
	logic [7:0] cmd_q;
	logic rd_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;
	logic done_q;
	logic nack_q;
	logic [31:0] prdata_q;
	wire wr_w;
	wire hit_w;
	wire go_w;
	wire clr_done_w;
	wire set_done_w;
	wire [31:0] rmux_w;

	assign wr_w = psel_i & penable_i & pwrite_i;
	assign hit_w = (paddr_i == `DSR_REG_CMD) | (paddr_i == `DSR_REG_WDATA)
		| (paddr_i == `DSR_REG_STATUS) | (paddr_i == `DSR_REG_RDATA);
	// a go while busy is dropped without error
	assign go_w = wr_w & (paddr_i == `DSR_REG_CMD) & pwdata_i[`DSR_CMD_GO_POS] & (state_q == HST_IDLE);
	assign clr_done_w = wr_w & (paddr_i == `DSR_REG_STATUS) & pwdata_i[`DSR_ST_DONE_POS];
	assign rmux_w = (paddr_i == `DSR_REG_CMD) ? {23'h0, rd_q, cmd_q} :
		(paddr_i == `DSR_REG_WDATA) ? {24'h0, wdata_q} :
		(paddr_i == `DSR_REG_STATUS) ? {29'h0, nack_q, done_q, state_q != HST_IDLE} :
		(paddr_i == `DSR_REG_RDATA) ? {24'h0, rdata_q} : 32'h0;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~hit_w;
	assign prdata_o = prdata_q;

	// ****************************************
	// bit timing and sequencing
	// ****************************************
	logic [15:0] tmr_q;
	logic [1:0] q_q;
	logic [3:0] slot_q;
	logic [1:0] byte_q;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic mnack_q;
	logic sda_m_q;
	logic sda_s_q;
	wire tick_w;
	wire end_w;
	wire txing_w;

	assign tick_w = (tmr_q == 16'h0);
	assign end_w = tick_w & (q_q == 2'd3);
	assign txing_w = (byte_q != 2'd3);
	assign set_done_w = end_w & (state_q == HST_STOP);

	// quarter-period timer and sda synchroniser
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tmr_q <= 16'h0;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			tmr_q <= (tick_w || state_q == HST_IDLE) ? 16'(QTR_CYC - 1) : tmr_q - 16'd1;
			sda_m_q <= bus.sda;
			sda_s_q <= sda_m_q;
		end
	end

	// sequencer: start, bytes, optional repeated start, stop
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= HST_IDLE;
			q_q <= 2'd0;
			slot_q <= 4'd0;
			byte_q <= 2'd0;
			tx_q <= 8'hff;
			rx_q <= 8'h00;
			mnack_q <= 1'b0;
		end else if (go_w) begin
			state_q <= HST_START;
			q_q <= 2'd0;
		end else if (state_q != HST_IDLE && tick_w) begin
			q_q <= q_q + 2'd1;
			if (q_q == 2'd2 && state_q == HST_BYTE) begin
				if (slot_q == 4'd8) begin
					mnack_q <= sda_s_q;
				end else begin
					rx_q <= {rx_q[6:0], sda_s_q};
				end
			end
			if (q_q == 2'd3) begin
				slot_q <= 4'd0;
				case (state_q)
					HST_START: begin
						state_q <= HST_BYTE;
						byte_q <= 2'd0;
						tx_q <= tx_byte(2'd0, rd_q, cmd_q, wdata_q);
					end
					HST_BYTE: begin
						if (slot_q != 4'd8) begin
							slot_q <= slot_q + 4'd1;
							tx_q <= {tx_q[6:0], 1'b1};
						end else if ((txing_w && mnack_q) || byte_q == 2'd3) begin
							state_q <= HST_STOP;
						end else if (byte_q == 2'd1 && rd_q) begin
							state_q <= HST_RSTART;
						end else if (byte_q == 2'd2 && !rd_q) begin
							state_q <= HST_STOP;
						end else begin
							byte_q <= byte_q + 2'd1;
							tx_q <= tx_byte(byte_q + 2'd1, rd_q, cmd_q, wdata_q);
						end
					end
					HST_RSTART: begin
						state_q <= HST_BYTE;
						byte_q <= 2'd2;
						tx_q <= tx_byte(2'd2, rd_q, cmd_q, wdata_q);
					end
					default: begin
						state_q <= HST_IDLE;
					end
				endcase
			end
		end
	end

	// software registers; done set wins over a clear in the same cycle
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd_q <= `DSR_CMD_OUTPUT_CODE;
			rd_q <= 1'b0;
			wdata_q <= 8'h00;
			rdata_q <= 8'h00;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			if (go_w) begin
				cmd_q <= pwdata_i[7:0];
				rd_q <= pwdata_i[`DSR_CMD_RD_POS];
			end
			if (wr_w && paddr_i == `DSR_REG_WDATA) begin
				wdata_q <= pwdata_i[7:0];
			end
			if (end_w && state_q == HST_BYTE && slot_q == 4'd8 && byte_q == 2'd3) begin
				rdata_q <= rx_q;
			end
			done_q <= set_done_w | (done_q & ~clr_done_w);
			if (go_w) begin
				nack_q <= 1'b0;
			end else if (end_w && state_q == HST_BYTE && slot_q == 4'd8 && txing_w && mnack_q) begin
				nack_q <= 1'b1;
			end
			if (psel_i && !penable_i) begin
				prdata_q <= rmux_w;
			end
		end
	end

	// ****************************************
	// line drive, open drain
	// ****************************************
	// scl low outside the high half of each slot, and only in the first quarter of stop; no clock stretching is honoured
	assign bus.host_scl_o = 1'b0;
	assign bus.host_scl_oe = ((state_q == HST_START) & q_q[1])
		| (((state_q == HST_BYTE) | (state_q == HST_RSTART)) & (q_q == 2'd0 || q_q == 2'd3))
		| ((state_q == HST_STOP) & (q_q == 2'd0));
	// ninth slot released for the device ack, or as nack after the read byte
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe = ((state_q == HST_START) & (q_q != 2'd0))
		| ((state_q == HST_BYTE) & (slot_q != 4'd8) & txing_w & ~tx_q[7])
		| ((state_q == HST_RSTART) & q_q[1])
		| ((state_q == HST_STOP) & ~q_q[1]);

endmodule : dsr_host
`default_nettype wire

/* src/dsr_params.svh */
// constants of the dac serial port: addresses, codes, fields, resets, timing
//
// Operation
// - master sends address first after START
// - acknowledge only slave address 1001000
// - eighth address bit: 1 read, 0 write
// - first phase writes command byte, direction 0
// - ninth clock: master releases, device pulls low
// - after address ack, data flows
// - acknowledge after data byte is written
// - master ends each transaction with STOP
// - command 00h output code, 01h setup
// - setup bit0 standby, bits 7:1 read zero
// - output code drives converter, msb first
// - both registers eight bits, reset zero
// - every byte shifted msb first
// - ignore bus until START seen
`ifndef DSR_PARAMS_SVH
`define DSR_PARAMS_SVH

// ****************************************
// slave side
// ****************************************
`define DSR_SLAVE_ADDR 7'h48
`define DSR_DIR_READ 1'b1
`define DSR_DIR_WRITE 1'b0
`define DSR_CMD_OUTPUT_CODE 8'h00
`define DSR_CMD_SETUP 8'h01
`define DSR_STANDBY_BIT 0
`define DSR_OUTPUT_CODE_RST 8'h00
`define DSR_SETUP_RST 1'b0

// ****************************************
// controller registers on apb
// ****************************************
`define DSR_REG_CMD 8'h00
`define DSR_REG_WDATA 8'h04
`define DSR_REG_STATUS 8'h08
`define DSR_REG_RDATA 8'h0c
`define DSR_CMD_RD_POS 8
`define DSR_CMD_GO_POS 9
`define DSR_ST_BUSY_POS 0
`define DSR_ST_DONE_POS 1
`define DSR_ST_NACK_POS 2

// ****************************************
// timing
// ****************************************
`define DSR_MCLK_PERIOD_NS 5
`define DSR_SCL_PERIOD_NS 10000
`define DSR_QTR_CYC ((`DSR_SCL_PERIOD_NS / 4) / `DSR_MCLK_PERIOD_NS)

`endif

/* src/dsr_pkg.sv */
// types shared by both ends of the dac serial port
`default_nettype none
package dsr_pkg;

	// device states, gray along address, command, data
	typedef enum logic [3:0] {
		DEV_IDLE = 4'h0,
		DEV_ADDR = 4'h1,
		DEV_ADDR_ACK = 4'h3,
		DEV_CMD = 4'h2,
		DEV_CMD_ACK = 4'h6,
		DEV_WDATA = 4'h7,
		DEV_WDATA_ACK = 4'h5,
		DEV_RDATA = 4'h4,
		DEV_RDATA_ACK = 4'hc
	} dsr_dev_state_e;

	// controller states
	typedef enum logic [2:0] {
		HST_IDLE = 3'h0,
		HST_START = 3'h1,
		HST_BYTE = 3'h3,
		HST_RSTART = 3'h2,
		HST_STOP = 3'h6
	} dsr_host_state_e;

endpackage : dsr_pkg
`default_nettype wire
